// ===== verilog/mrc_pkg.sv
// mrc_pkg: constants, register map and carriers of the low-power resistance command core
// assumes one 250 MHz clock and an AXI4-Lite master with 8-bit byte addresses
package mrc_pkg;
    localparam int ADDR_W = 8;
    localparam int N_RNG = 6;
    localparam int N_SPD = 3;
    // register byte offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_ARG = 8'h04;
    localparam logic [7:0] A_RESULT = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    localparam logic [7:0] A_EVENT_STATUS = 8'h10;
    localparam logic [7:0] A_IRQ_STAT = 8'h14;
    localparam logic [7:0] A_IRQ_MASK = 8'h18;
    localparam logic [7:0] A_COMM_CFG = 8'h1c;
    localparam logic [7:0] A_LAST = 8'h1c;
    // command word fields
    localparam int CMD_ITEM_LSB = 0;
    localparam int CMD_QRY_BIT = 4;
    localparam int CMD_RNG_LSB = 5;
    localparam int CMD_SPD_LSB = 8;
    typedef enum logic [3:0] {
        IT_IDN, IT_RST, IT_TST, IT_OP_COMPLETE, IT_BACKUP, IT_SECOND_DELAY, IT_NPLC, IT_APER,
        IT_CIMP, IT_CIMP_LVL, IT_CURR, IT_CC, IT_CC_LVL, IT_VMON, IT_VMON_LVL
    } mrc_item_t;
    // event status bits
    localparam int EVT_OP_COMPLETE = 0;
    localparam int EVT_EXE = 4;
    localparam int EVT_CME = 5;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_AVAIL = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_OP_COMPLETE = 3;
    // argument limits, delay and integration_seconds in 100 us units, line cycles in 0.01 units
    localparam logic [31:0] D2_MAX = 32'h0000_03e8;
    localparam logic [31:0] NPLC_MIN = 32'h0000_0001;
    localparam logic [31:0] NPLC_MAX = 32'h0000_0258;
    localparam logic [31:0] APER_MIN = 32'h0000_0001;
    localparam logic [31:0] APER_MAX = 32'h0000_03e8;
    localparam logic [31:0] CIMP_MAX = 32'h0000_0002;
    localparam logic [31:0] CIMP_LVL_MAX = 32'h0000_0004;
    localparam logic [31:0] CC_LVL_MAX = 32'h0000_0007;
    localparam logic [31:0] VMON_LVL_MAX = 32'h0000_0003;
    localparam logic [31:0] ASCII_ONE = 32'h0000_0031;
    localparam logic [7:0] TEST_CYCLES = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // identification words, values arbitrary
    localparam logic [31:0] ID_MAKER = 32'h4d41_4b52;
    localparam logic [31:0] ID_MODEL = 32'h4d4f_444c;
    localparam logic [31:0] ID_VERSION = 32'h0000_0100;

    typedef struct packed {
        logic [9:0] second_delay;
        logic [2:0][9:0] nplc;
        logic [2:0][9:0] aper;
        logic [2:0] int_sec;
        logic [1:0] cimp;
        logic [2:0] cimp_lvl;
        logic curr_cont;
        logic cc_en;
        logic [2:0] cc_lvl;
        logic vmon_en;
        logic [1:0] vmon_lvl;
    } mrc_set_t;

    localparam mrc_set_t SET_DEFAULT = '{
        second_delay: 10'h000, nplc: {3{10'h064}}, aper: {3{10'h064}}, int_sec: 3'h0,
        cimp: 2'h0, cimp_lvl: 3'h1, curr_cont: 1'h1, cc_en: 1'h0, cc_lvl: 3'h1,
        vmon_en: 1'h0, vmon_lvl: 2'h1};

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } mrc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mrc_axi_rsp_t;
endpackage

// ===== verilog/mrc_range_table.sv
// mrc_range_table: per-range settings storage in flip-flops
// assumes the caller writes one entry at a time and raises init_in for a device reset
module mrc_range_table (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // write side
    input wire logic init_in,
    input wire logic wr_in,
    input wire logic [2:0] wr_idx_in,
    input wire mrc_pkg::mrc_set_t wr_data_in,
    // read side
    input wire logic [2:0] rd_idx_in,
    output mrc_pkg::mrc_set_t rd_data_out
);
    mrc_pkg::mrc_set_t tbl_r [mrc_pkg::N_RNG];
    mrc_pkg::mrc_set_t tbl_nxt [mrc_pkg::N_RNG];

    genvar g;
    generate
        for (g = 0; g < mrc_pkg::N_RNG; g++) begin : g_ent
            // only the named entry changes on a write, init_in loads defaults into every entry
            always_comb begin
                tbl_nxt[g] = tbl_r[g];
                if (init_in) begin
                    tbl_nxt[g] = mrc_pkg::SET_DEFAULT;
                end else if (wr_in && wr_idx_in == 3'(g)) begin
                    tbl_nxt[g] = wr_data_in;
                end
            end
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    tbl_r[g] <= mrc_pkg::SET_DEFAULT;
                end else begin
                    tbl_r[g] <= tbl_nxt[g];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_data_out = mrc_pkg::SET_DEFAULT;
        if (rd_idx_in < 3'(mrc_pkg::N_RNG)) begin
            rd_data_out = tbl_r[rd_idx_in];
        end
    end
endmodule

// ===== verilog/mrc_core.sv
// mrc_core: command interpreter for low-power resistance settings and common commands
// assumes an AXI4-Lite master and memory fault pins from outside the clock domain
module mrc_core (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // register bus
    input wire mrc_pkg::mrc_axi_req_t axi_in,
    output mrc_pkg::mrc_axi_rsp_t axi_out,
    // memory fault pins
    input wire logic [2:0] mem_fault_in,
    // system
    output logic irq_out,
    output logic backup_req_out
);
    typedef enum logic {S_IDLE, S_TEST} mrc_fsm_t;
    typedef struct packed {
        mrc_pkg::mrc_axi_rsp_t rsp;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] cmd;
        logic [31:0] arg;
        logic [31:0] result;
        logic out_avail;
        logic [7:0] event_status;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [31:0] comm_cfg;
        logic irq;
        logic backup_req;
        mrc_fsm_t fsm;
        logic [7:0] tcnt;
        logic op_complete_pend;
        logic op_complete_qry;
        logic [2:0] flt_s1;
        logic [2:0] flt_s2;
    } mrc_st_t;

    mrc_st_t st_r;
    mrc_st_t st_nxt;
    mrc_pkg::mrc_set_t rec;
    mrc_pkg::mrc_set_t rec_new;
    logic tbl_wr;
    logic tbl_init;
    logic go;
    logic q;
    mrc_pkg::mrc_item_t item;
    logic [2:0] rng;
    logic [1:0] spd;
    logic [31:0] cmd_w;

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= mrc_pkg::A_LAST;
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic in_lim(input logic [31:0] v, input logic [31:0] lo,
                                    input logic [31:0] hi);
        return v >= lo && v <= hi;
    endfunction

    mrc_range_table u_tbl (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .init_in(tbl_init),
        .wr_in(tbl_wr),
        .wr_idx_in(rng),
        .wr_data_in(rec_new),
        .rd_idx_in(rng),
        .rd_data_out(rec)
    );

    assign cmd_w = wmerge(32'h0, st_r.wdata, st_r.wstrb);
    assign item = mrc_pkg::mrc_item_t'(cmd_w[mrc_pkg::CMD_ITEM_LSB +: 4]);
    assign q = cmd_w[mrc_pkg::CMD_QRY_BIT];
    assign rng = cmd_w[mrc_pkg::CMD_RNG_LSB +: 3];
    assign spd = cmd_w[mrc_pkg::CMD_SPD_LSB +: 2];

    always_comb begin
        logic do_wr;
        logic bad;
        logic clr_irq;
        logic clr_event_status;
        logic clr_av;
        logic av_set;
        logic [3:0] ev;
        logic [7:0] event_status_set;
        logic [31:0] a;
        do_wr = 1'b0;
        bad = 1'b0;
        clr_irq = 1'b0;
        clr_event_status = 1'b0;
        clr_av = 1'b0;
        av_set = 1'b0;
        ev = 4'h0;
        event_status_set = 8'h00;
        a = st_r.arg;
        st_nxt = st_r;
        st_nxt.backup_req = 1'b0;
        st_nxt.flt_s1 = mem_fault_in;
        st_nxt.flt_s2 = st_r.flt_s1;
        rec_new = rec;
        tbl_wr = 1'b0;
        tbl_init = 1'b0;
        go = 1'b0;
        // bus handshakes
        if (axi_in.bready && st_r.rsp.bvalid) begin
            st_nxt.rsp.bvalid = 1'b0;
        end
        if (axi_in.rready && st_r.rsp.rvalid) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        if (axi_in.awvalid && st_r.rsp.awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = axi_in.awaddr;
        end
        if (axi_in.wvalid && st_r.rsp.wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = axi_in.wdata;
            st_nxt.wstrb = axi_in.wstrb;
        end
        if (st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid) begin
            do_wr = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp = mapped(st_r.awaddr) ? mrc_pkg::RESP_OKAY : mrc_pkg::RESP_SLVERR;
        end
        if (do_wr) begin
            case (st_r.awaddr)
                mrc_pkg::A_CMD: begin
                    st_nxt.cmd = cmd_w;
                    go = 1'b1;
                end
                mrc_pkg::A_ARG: st_nxt.arg = wmerge(st_r.arg, st_r.wdata, st_r.wstrb);
                mrc_pkg::A_IRQ_MASK: begin
                    st_nxt.irq_mask = 4'(wmerge(32'(st_r.irq_mask), st_r.wdata, st_r.wstrb));
                end
                mrc_pkg::A_COMM_CFG: begin
                    st_nxt.comm_cfg = wmerge(st_r.comm_cfg, st_r.wdata, st_r.wstrb);
                end
                default: ;
            endcase
        end
        // command execution
        if (go && st_r.fsm != S_IDLE && item != mrc_pkg::IT_OP_COMPLETE) begin
            event_status_set[mrc_pkg::EVT_EXE] = 1'b1;
            ev[mrc_pkg::IRQ_ERR] = 1'b1;
        end else if (go) begin
            ev[mrc_pkg::IRQ_DONE] = 1'b1;
            bad = item >= mrc_pkg::IT_SECOND_DELAY
                && (rng >= 3'(mrc_pkg::N_RNG) || 32'(spd) >= 32'(mrc_pkg::N_SPD));
            case (item)
                mrc_pkg::IT_IDN: begin
                    av_set = 1'b1;
                    case (a[1:0])
                        2'h0: st_nxt.result = mrc_pkg::ID_MAKER;
                        2'h1: st_nxt.result = mrc_pkg::ID_MODEL;
                        2'h2: st_nxt.result = 32'h0;
                        default: st_nxt.result = mrc_pkg::ID_VERSION;
                    endcase
                end
                mrc_pkg::IT_RST: tbl_init = 1'b1;
                mrc_pkg::IT_TST: begin
                    st_nxt.fsm = S_TEST;
                    st_nxt.tcnt = 8'h0;
                end
                mrc_pkg::IT_OP_COMPLETE: begin
                    if (q) begin
                        st_nxt.op_complete_qry = 1'b1;
                    end else begin
                        st_nxt.op_complete_pend = 1'b1;
                    end
                end
                mrc_pkg::IT_BACKUP: st_nxt.backup_req = 1'b1;
                mrc_pkg::IT_SECOND_DELAY: begin
                    st_nxt.result = 32'(rec.second_delay);
                    bad = bad || !in_lim(a, 32'h0, mrc_pkg::D2_MAX);
                    rec_new.second_delay = a[9:0];
                end
                mrc_pkg::IT_NPLC: begin
                    st_nxt.result = 32'(rec.nplc[spd]);
                    bad = bad || !in_lim(a, mrc_pkg::NPLC_MIN, mrc_pkg::NPLC_MAX);
                    rec_new.nplc[spd] = a[9:0];
                    rec_new.int_sec[spd] = 1'b0;
                end
                mrc_pkg::IT_APER: begin
                    st_nxt.result = 32'(rec.aper[spd]);
                    bad = bad || !in_lim(a, mrc_pkg::APER_MIN, mrc_pkg::APER_MAX);
                    rec_new.aper[spd] = a[9:0];
                    rec_new.int_sec[spd] = 1'b1;
                end
                mrc_pkg::IT_CIMP: begin
                    st_nxt.result = 32'(rec.cimp);
                    bad = bad || !in_lim(a, 32'h0, mrc_pkg::CIMP_MAX);
                    rec_new.cimp = a[1:0];
                end
                mrc_pkg::IT_CIMP_LVL: begin
                    st_nxt.result = 32'(rec.cimp_lvl);
                    bad = bad || !in_lim(a, 32'h1, mrc_pkg::CIMP_LVL_MAX);
                    rec_new.cimp_lvl = a[2:0];
                end
                mrc_pkg::IT_CURR: begin
                    st_nxt.result = 32'(rec.curr_cont);
                    bad = bad || a > 32'h1;
                    rec_new.curr_cont = a[0];
                end
                mrc_pkg::IT_CC: begin
                    st_nxt.result = 32'(rec.cc_en);
                    bad = bad || a > 32'h1;
                    rec_new.cc_en = a[0];
                end
                mrc_pkg::IT_CC_LVL: begin
                    st_nxt.result = 32'(rec.cc_lvl);
                    bad = bad || !in_lim(a, 32'h1, mrc_pkg::CC_LVL_MAX);
                    rec_new.cc_lvl = a[2:0];
                end
                mrc_pkg::IT_VMON: begin
                    st_nxt.result = 32'(rec.vmon_en);
                    bad = bad || a > 32'h1;
                    rec_new.vmon_en = a[0];
                end
                mrc_pkg::IT_VMON_LVL: begin
                    st_nxt.result = 32'(rec.vmon_lvl);
                    bad = bad || !in_lim(a, 32'h1, mrc_pkg::VMON_LVL_MAX);
                    rec_new.vmon_lvl = a[1:0];
                end
                default: bad = 1'b1;
            endcase
            if (item >= mrc_pkg::IT_SECOND_DELAY) begin
                // queries leave the table, settings write only their range
                if (q) begin
                    // query argument ignored, only range and speed refuse it
                    bad = bad && (rng >= 3'(mrc_pkg::N_RNG) || 32'(spd) >= 32'(mrc_pkg::N_SPD));
                    av_set = !bad;
                    if (bad) begin
                        st_nxt.result = st_r.result;
                    end
                end else begin
                    st_nxt.result = st_r.result;
                    tbl_wr = !bad;
                end
            end
            if (bad) begin
                event_status_set[mrc_pkg::EVT_CME] = 1'b1;
                ev[mrc_pkg::IRQ_ERR] = 1'b1;
            end
        end
        // self-test sequence, and the deferred operation-complete reports while idle
        case (st_r.fsm)
            S_IDLE: begin
                if (st_r.op_complete_pend) begin
                    st_nxt.op_complete_pend = 1'b0;
                    event_status_set[mrc_pkg::EVT_OP_COMPLETE] = 1'b1;
                    ev[mrc_pkg::IRQ_OP_COMPLETE] = 1'b1;
                end
                if (st_r.op_complete_qry) begin
                    st_nxt.op_complete_qry = 1'b0;
                    st_nxt.result = mrc_pkg::ASCII_ONE;
                    av_set = 1'b1;
                end
            end
            S_TEST: begin
                st_nxt.tcnt = st_r.tcnt + 8'h1;
                if (st_r.tcnt == mrc_pkg::TEST_CYCLES - 8'h1) begin
                    st_nxt.fsm = S_IDLE;
                    st_nxt.result = {29'h0, st_r.flt_s2};
                    av_set = 1'b1;
                end
            end
            default: st_nxt.fsm = S_IDLE;
        endcase
        // register reads
        if (axi_in.arvalid && st_r.rsp.arready) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rresp = mapped(axi_in.araddr) ? mrc_pkg::RESP_OKAY : mrc_pkg::RESP_SLVERR;
            case (axi_in.araddr)
                mrc_pkg::A_CMD: st_nxt.rsp.rdata = st_r.cmd;
                mrc_pkg::A_ARG: st_nxt.rsp.rdata = st_r.arg;
                mrc_pkg::A_RESULT: begin
                    st_nxt.rsp.rdata = st_r.result;
                    clr_av = 1'b1;
                end
                mrc_pkg::A_STAT: begin
                    st_nxt.rsp.rdata = {29'h0, st_r.op_complete_pend, st_r.out_avail,
                                        st_r.fsm == S_TEST};
                end
                mrc_pkg::A_EVENT_STATUS: begin
                    st_nxt.rsp.rdata = 32'(st_r.event_status);
                    clr_event_status = 1'b1;
                end
                mrc_pkg::A_IRQ_STAT: begin
                    st_nxt.rsp.rdata = 32'(st_r.irq_stat);
                    clr_irq = 1'b1;
                end
                mrc_pkg::A_IRQ_MASK: st_nxt.rsp.rdata = 32'(st_r.irq_mask);
                mrc_pkg::A_COMM_CFG: st_nxt.rsp.rdata = st_r.comm_cfg;
                default: st_nxt.rsp.rdata = 32'h0;
            endcase
        end
        // sticky bits, a new event wins over the read clear
        ev[mrc_pkg::IRQ_AVAIL] = av_set;
        st_nxt.out_avail = (st_r.out_avail && !clr_av) || av_set;
        st_nxt.event_status = (clr_event_status ? 8'h00 : st_r.event_status) | event_status_set;
        st_nxt.irq_stat = (clr_irq ? 4'h0 : st_r.irq_stat) | ev;
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
        st_nxt.rsp.awready = !st_nxt.aw_got;
        st_nxt.rsp.wready = !st_nxt.w_got;
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axi_out = st_r.rsp;
    assign irq_out = st_r.irq;
    assign backup_req_out = st_r.backup_req;

    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_idn;
        go && item == mrc_pkg::IT_IDN && st_r.fsm == S_IDLE && st_r.arg[1:0] == 2'h2
            |=> st_r.result == 32'h0 && st_r.out_avail;
    endproperty
    a_idn: assert property (p_idn) else $error("id zero field wrong");

    property p_rst_comm;
        tbl_init |=> $stable(st_r.comm_cfg);
    endproperty
    a_rst_comm: assert property (p_rst_comm) else $error("reset changed comm cfg");

    property p_rst_nobak;
        tbl_init |=> !backup_req_out;
    endproperty
    a_rst_nobak: assert property (p_rst_nobak) else $error("reset asked backup");

    property p_tst_val;
        st_r.fsm == S_TEST && st_r.tcnt == mrc_pkg::TEST_CYCLES - 8'h1
            |=> st_r.result[2:0] == $past(st_r.flt_s2) && st_r.fsm == S_IDLE;
    endproperty
    a_tst_val: assert property (p_tst_val) else $error("self-test value wrong");

    property p_tst_hi;
        go && item == mrc_pkg::IT_TST && st_r.fsm == S_IDLE
            |=> (st_r.fsm == S_TEST && st_r.tcnt == 8'h00)
            ##15 (st_r.fsm == S_TEST && st_r.tcnt == mrc_pkg::TEST_CYCLES - 8'h1)
            ##1 (st_r.fsm == S_IDLE && st_r.result[31:3] == 29'h0);
    endproperty
    a_tst_hi: assert property (p_tst_hi) else $error("self-test length or bits wrong");

    property p_op_complete;
        st_r.op_complete_pend && st_r.fsm == S_IDLE
            |=> st_r.event_status[mrc_pkg::EVT_OP_COMPLETE] && !st_r.op_complete_pend;
    endproperty
    a_op_complete: assert property (p_op_complete) else $error("complete bit not set");

    property p_op_complete_qry;
        st_r.op_complete_qry && st_r.fsm == S_TEST |=> st_r.op_complete_qry;
    endproperty
    a_op_complete_qry: assert property (p_op_complete_qry) else $error("early answer");

    property p_d2;
        go && item == mrc_pkg::IT_SECOND_DELAY && !q && st_r.arg > mrc_pkg::D2_MAX |-> !tbl_wr;
    endproperty
    a_d2: assert property (p_d2) else $error("out of range delay stored");
endmodule

// ===== testbench/mrc_host_model.sv
// mrc_host_model: register bus master standing in for the host computer
// assumes one clock; bench calls wr and rd one at a time
module mrc_host_model (
    // clock
    input wire logic clk_in,
    // register bus
    input wire mrc_pkg::mrc_axi_rsp_t axi_rsp_in,
    output mrc_pkg::mrc_axi_req_t axi_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial axi_req_out = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        axi_req_out.awvalid <= 1'b1;
        axi_req_out.awaddr <= a;
        axi_req_out.wvalid <= 1'b1;
        axi_req_out.wdata <= d;
        axi_req_out.wstrb <= 4'hf;
        axi_req_out.bready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (axi_req_out.awvalid && axi_rsp_in.awready) axi_req_out.awvalid <= 1'b0;
            if (axi_req_out.wvalid && axi_rsp_in.wready) axi_req_out.wvalid <= 1'b0;
            if (axi_rsp_in.bvalid) begin
                r = axi_rsp_in.bresp;
                axi_req_out.bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        axi_req_out.arvalid <= 1'b1;
        axi_req_out.araddr <= a;
        axi_req_out.rready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (axi_req_out.arvalid && axi_rsp_in.arready) axi_req_out.arvalid <= 1'b0;
            if (axi_rsp_in.rvalid) begin
                d = axi_rsp_in.rdata;
                r = axi_rsp_in.rresp;
                axi_req_out.rready <= 1'b0;
                break;
            end
        end
    endtask
endmodule

// ===== testbench/test_meter_remote_command_core.sv
// test_meter_remote_command_core: self-checking bench of the command core
// assumes mrc_core as top and the host model as bus master
module test_meter_remote_command_core;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] fault = 3'h0;
    logic irq, bk;
    mrc_pkg::mrc_axi_req_t req;
    mrc_pkg::mrc_axi_rsp_t rsp;
    int err_total = 0;
    int compares = 0;
    int bk_cnt = 0;
    logic [31:0] v;
    logic [1:0] r;
    always #2 clk = ~clk;
    always @(posedge clk) if (bk === 1'b1) bk_cnt++;
    mrc_core mrc_core_inst (.clk_in(clk), .reset_in(rst), .axi_in(req), .axi_out(rsp),
        .mem_fault_in(fault), .irq_out(irq), .backup_req_out(bk));
    mrc_host_model mrc_host_model_inst (.clk_in(clk), .axi_rsp_in(rsp), .axi_req_out(req));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic cmd(input logic [3:0] it, input logic q, input logic [2:0] rg,
        input logic [1:0] sp, input logic [31:0] a);
        mrc_host_model_inst.wr(mrc_pkg::A_ARG, a, r);
        mrc_host_model_inst.wr(mrc_pkg::A_CMD, {22'h0, sp, rg, q, it}, r);
    endtask
    task automatic qry(input logic [3:0] it, input logic [2:0] rg, input logic [1:0] sp);
        cmd(it, 1'b1, rg, sp, 32'h0);
        mrc_host_model_inst.rd(mrc_pkg::A_STAT, v, r);
        chk("avail", {31'h0, v[1]}, 32'h1);
        mrc_host_model_inst.rd(mrc_pkg::A_RESULT, v, r);
    endtask
    task automatic t_idn;
        logic [31:0] exp[4];
        exp = '{mrc_pkg::ID_MAKER, mrc_pkg::ID_MODEL, 32'h0, mrc_pkg::ID_VERSION};
        for (int i = 0; i < 4; i++) begin
            cmd(4'h0, 1'b1, 3'h0, 2'h0, i);
            mrc_host_model_inst.rd(mrc_pkg::A_RESULT, v, r);
            chk("idn", v, exp[i]);
        end
        mrc_host_model_inst.rd(8'h20, v, r);
        chk("unmapped", {30'h0, r}, {30'h0, mrc_pkg::RESP_SLVERR});
        $display("test idn done");
    endtask
    task automatic t_set;
        logic [3:0] it[10];
        logic [31:0] val[10];
        it = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
        val = '{32'h3e8, 32'h258, 32'h3e8, 32'h2, 32'h4, 32'h0, 32'h1, 32'h7, 32'h1, 32'h3};
        for (int i = 0; i < 10; i++) begin
            cmd(it[i], 1'b0, 3'h5, 2'h2, val[i]);
            qry(it[i], 3'h5, 2'h2);
            chk("setting", v, val[i]);
        end
        qry(4'h5, 3'h4, 2'h0);
        chk("other range", v, 32'h0);
        mrc_host_model_inst.rd(mrc_pkg::A_EVENT_STATUS, v, r);
        cmd(4'hc, 1'b0, 3'h5, 2'h0, 32'h8);
        mrc_host_model_inst.rd(mrc_pkg::A_EVENT_STATUS, v, r);
        chk("bad level", {31'h0, v[5]}, 32'h1);
        qry(4'hc, 3'h5, 2'h0);
        chk("level kept", v, 32'h7);
        cmd(4'h5, 1'b0, 3'h5, 2'h2, 32'h3e9);
        qry(4'h5, 3'h5, 2'h2);
        chk("delay kept", v, 32'h3e8);
        $display("test settings done");
    endtask
    task automatic t_rst;
        mrc_host_model_inst.wr(mrc_pkg::A_COMM_CFG, 32'h5a, r);
        cmd(4'h1, 1'b0, 3'h0, 2'h0, 32'h0);
        qry(4'h5, 3'h5, 2'h0);
        chk("delay default", v, 32'h0);
        qry(4'h9, 3'h5, 2'h0);
        chk("level default", v, 32'h1);
        mrc_host_model_inst.rd(mrc_pkg::A_COMM_CFG, v, r);
        chk("comm cfg", v, 32'h5a);
        chk("no backup", bk_cnt, 0);
        cmd(4'h4, 1'b0, 3'h0, 2'h0, 32'h0);
        repeat (4) @(posedge clk);
        chk("backup", bk_cnt, 1);
        $display("test reset done");
    endtask
    task automatic t_tst;
        logic [2:0] f[2];
        f = '{3'h5, 3'h0};
        foreach (f[i]) begin
            @(posedge clk) fault <= f[i];
            repeat (4) @(posedge clk);
            cmd(4'h2, 1'b1, 3'h0, 2'h0, 32'h0);
            v = 32'h1;
            for (int k = 0; k < 50 && v[0] !== 1'b0; k++)
                mrc_host_model_inst.rd(mrc_pkg::A_STAT, v, r);
            mrc_host_model_inst.rd(mrc_pkg::A_RESULT, v, r);
            chk("self test", v, {29'h0, f[i]});
        end
        $display("test self test done");
    endtask
    task automatic t_op_complete;
        mrc_host_model_inst.wr(mrc_pkg::A_IRQ_MASK, 32'h0, r);
        mrc_host_model_inst.rd(mrc_pkg::A_EVENT_STATUS, v, r);
        mrc_host_model_inst.rd(mrc_pkg::A_IRQ_STAT, v, r);
        cmd(4'h3, 1'b0, 3'h0, 2'h0, 32'h0);
        repeat (3) @(posedge clk);
        chk("irq masked", irq, 1'b0);
        mrc_host_model_inst.wr(mrc_pkg::A_IRQ_MASK, 32'h8, r);
        repeat (2) @(posedge clk);
        chk("irq raised", irq, 1'b1);
        mrc_host_model_inst.rd(mrc_pkg::A_EVENT_STATUS, v, r);
        chk("complete bit", {31'h0, v[0]}, 32'h1);
        mrc_host_model_inst.rd(mrc_pkg::A_IRQ_STAT, v, r);
        repeat (2) @(posedge clk);
        chk("irq cleared", irq, 1'b0);
        // answer must wait for the self-test issued ahead of it
        cmd(4'h2, 1'b1, 3'h0, 2'h0, 32'h0);
        cmd(4'h3, 1'b1, 3'h0, 2'h0, 32'h0);
        repeat (24) @(posedge clk);
        mrc_host_model_inst.rd(mrc_pkg::A_RESULT, v, r);
        chk("complete query", v, mrc_pkg::ASCII_ONE);
        $display("test complete done");
    endtask
    task automatic give_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_idn;
        t_set;
        t_rst;
        t_tst;
        t_op_complete;
        give_verdict;
    end
    initial begin
        #200000;
        err_total++;
        give_verdict;
    end
endmodule
